//--- src/dpfc_top.sv
// PLL feedback configuration registers and their effect on the loop
`timescale 1ns/1ps
`default_nettype none

module dpfc_top
   import dpfc_pkg::*;
#(
   parameter int FE_W        = 16,
   parameter int HIST_CYCLES = DPFC_HIST_CYC
) (
   input  wire logic                   sys_clk_in,
   input  wire logic                   rst_n_in,
   input  wire logic [15:0]            reg_addr_in,
   input  wire logic                   reg_wr_in,
   input  wire logic                   reg_rd_in,
   input  wire logic [7:0]             reg_wdata_in,
   output logic      [7:0]             reg_rdata_out,
   output logic                        reg_rvalid_out,
   input  wire logic                   phase_locked_in,
   input  wire logic [3:0]             locked_bw_in,
   input  wire logic [2:0]             locked_damp_in,
   input  wire logic [3:0]             acq_bw_in,
   input  wire logic [2:0]             acq_damp_in,
   output logic      [3:0]             loop_bw_out,
   output logic      [2:0]             loop_damp_out,
   output logic                        acquiring_out,
   input  wire logic [7:0]             phase_err_in,
   output logic                        in_window_out,
   input  wire logic [1:0]             hold_mode_in,
   output dpfc_avg_t                   avg_mode_out,
   output logic                        hist_tick_out,
   output logic      [29:0]            fb_value_out,
   output logic                        dsm_enable_out,
   output logic      [1:0]             dsm_order_out,
   input  wire logic signed [FE_W-1:0] freq_err_in,
   output logic signed [FE_W+1:0]      dco_err_out,
   output logic      [6:0]             dither_amp_out
);

   localparam int HCW = $clog2(HIST_CYCLES);
   localparam logic [HCW-1:0] HIST_LAST = HCW'(HIST_CYCLES - 1);

   logic        fast_q;
   logic        havg_q;
   logic [7:0]  win_q;
   logic [8:0]  int_q;
   logic [20:0] frac_q;
   logic [1:0]  ord_q;
   logic [1:0]  gain_q;
   logic [2:0]  dith_q;
   logic [HCW-1:0] hist_cnt_q;

   // Scales the error; half rounds toward minus infinity
   function automatic logic signed [FE_W+1:0] dpfc_scale(
      input logic signed [FE_W-1:0] e,
      input logic [1:0]             g
   );
      logic signed [FE_W+1:0] x;
      x = {{2{e[FE_W-1]}}, e};
      case (g)
         DPFC_GAIN_HALF: dpfc_scale = x >>> 1;
         DPFC_GAIN_ONE:  dpfc_scale = x;
         DPFC_GAIN_TWO:  dpfc_scale = x <<< 1;
         default:        dpfc_scale = x <<< 2;
      endcase
   endfunction

   // Dither magnitude in LSBs from the three-bit code
   function automatic logic [6:0] dpfc_dither(input logic [2:0] c);
      if (c == DPFC_DITH_NONE) begin
         dpfc_dither = '0;
      end else begin
         dpfc_dither = DPFC_DITH_LSB << (c - 3'h1);
      end
   endfunction

   // Read-back mux; reserved and unmapped bits read as zero
   function automatic logic [7:0] dpfc_read(input logic [15:0] a);
      logic [7:0] r;
      r = '0;
      case (a)
         DPFC_ADDR_ENA: begin
            r[DPFC_FAST_BIT] = fast_q;
            r[DPFC_HAVG_BIT] = havg_q;
         end
         DPFC_ADDR_WIN:  r = win_q;
         DPFC_ADDR_INTH: r[0] = int_q[DPFC_INT_W-1];
         DPFC_ADDR_INTL: r = int_q[7:0];
         DPFC_ADDR_FR2:  r[4:0] = frac_q[DPFC_FRAC_W-1:16];
         DPFC_ADDR_FR1:  r = frac_q[15:8];
         DPFC_ADDR_FR0:  r = frac_q[7:0];
         DPFC_ADDR_ORD: begin
            r[DPFC_ORD_HI:DPFC_ORD_LO]   = ord_q;
            r[DPFC_GAIN_HI:DPFC_GAIN_LO] = gain_q;
            r[DPFC_DITH_HI:0]            = dith_q;
         end
         default: r = '0;
      endcase
      dpfc_read = r;
   endfunction

   // Enable bits
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         fast_q <= DPFC_RST_FAST;
         havg_q <= DPFC_RST_HAVG;
      end else if (reg_wr_in && reg_addr_in == DPFC_ADDR_ENA) begin
         fast_q <= reg_wdata_in[DPFC_FAST_BIT];
         havg_q <= reg_wdata_in[DPFC_HAVG_BIT];
      end
   end

   // Lock window; a zero write is stored as is, software must avoid it
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         win_q <= DPFC_RST_WIN;
      end else if (reg_wr_in && reg_addr_in == DPFC_ADDR_WIN) begin
         win_q <= reg_wdata_in;
      end
   end

   // Modulator integer part, split over two bytes
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         int_q <= DPFC_RST_INT;
      end else if (reg_wr_in && reg_addr_in == DPFC_ADDR_INTH) begin
         int_q[DPFC_INT_W-1] <= reg_wdata_in[0];
      end else if (reg_wr_in && reg_addr_in == DPFC_ADDR_INTL) begin
         int_q[7:0] <= reg_wdata_in;
      end
   end

   // Modulator fraction, three bytes; upper reserved bits dropped
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         frac_q <= DPFC_RST_FRAC;
      end else if (reg_wr_in) begin
         case (reg_addr_in)
            DPFC_ADDR_FR2: frac_q[DPFC_FRAC_W-1:16] <= reg_wdata_in[4:0];
            DPFC_ADDR_FR1: frac_q[15:8] <= reg_wdata_in;
            DPFC_ADDR_FR0: frac_q[7:0] <= reg_wdata_in;
            default: frac_q <= frac_q;
         endcase
      end
   end

   // Order, gain and dither byte; bit 3 is reserved and not stored
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         ord_q  <= DPFC_RST_ORD;
         gain_q <= DPFC_RST_GAIN;
         dith_q <= DPFC_RST_DITH;
      end else if (reg_wr_in && reg_addr_in == DPFC_ADDR_ORD) begin
         ord_q  <= reg_wdata_in[DPFC_ORD_HI:DPFC_ORD_LO];
         gain_q <= reg_wdata_in[DPFC_GAIN_HI:DPFC_GAIN_LO];
         dith_q <= reg_wdata_in[DPFC_DITH_HI:0];
      end
   end

   // Read data, one cycle after the strobe
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         reg_rdata_out  <= '0;
         reg_rvalid_out <= 1'b0;
      end else begin
         reg_rvalid_out <= reg_rd_in;
         if (reg_rd_in) begin
            reg_rdata_out <= dpfc_read(reg_addr_in);
         end
      end
   end

   // Loop parameter selection; registered so a lock change glitches nothing
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         loop_bw_out   <= '0;
         loop_damp_out <= '0;
         acquiring_out <= 1'b0;
      end else if (fast_q && !phase_locked_in) begin
         loop_bw_out   <= acq_bw_in;
         loop_damp_out <= acq_damp_in;
         acquiring_out <= 1'b1;
      end else begin
         loop_bw_out   <= locked_bw_in;
         loop_damp_out <= locked_damp_in;
         acquiring_out <= 1'b0;
      end
   end

   // Phase error, in the same 2.5 ns steps, against the window
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         in_window_out <= 1'b0;
      end else begin
         in_window_out <= (phase_err_in <= win_q);
      end
   end

   // Effective holdover averaging; reserved mode code treated as off
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         avg_mode_out <= DPFC_AVG_OFF;
      end else if (!havg_q) begin
         avg_mode_out <= DPFC_AVG_OFF;
      end else begin
         case (hold_mode_in)
            DPFC_HM_INST: avg_mode_out <= DPFC_AVG_INST;
            DPFC_HM_FAST: avg_mode_out <= DPFC_AVG_FAST;
            DPFC_HM_MID:  avg_mode_out <= DPFC_AVG_MID;
            default:      avg_mode_out <= DPFC_AVG_OFF;
         endcase
      end
   end

   // History sampling tick every 100 ms for instantaneous mode
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         hist_cnt_q    <= '0;
         hist_tick_out <= 1'b0;
      end else if (hist_cnt_q == HIST_LAST) begin
         hist_cnt_q    <= '0;
         hist_tick_out <= 1'b1;
      end else begin
         hist_cnt_q    <= hist_cnt_q + 1'b1;
         hist_tick_out <= 1'b0;
      end
   end

   // Modulator controls toward the feedback divider
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         fb_value_out   <= '0;
         dsm_enable_out <= 1'b0;
         dsm_order_out  <= DPFC_ORD_OFF;
      end else begin
         fb_value_out   <= {int_q, frac_q};
         dsm_enable_out <= (ord_q != DPFC_ORD_OFF);
         dsm_order_out  <= ord_q;
      end
   end

   // Oscillator error scaling and dither level
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         dco_err_out    <= '0;
         dither_amp_out <= '0;
      end else begin
         dco_err_out    <= dpfc_scale(freq_err_in, gain_q);
         dither_amp_out <= dpfc_dither(dith_q);
      end
   end

   // Checks on the configuration effects
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);

   a_fast_off_lock: assert property (
      $past(rst_n_in) && !$past(fast_q) |->
         loop_bw_out == $past(locked_bw_in) && loop_damp_out == $past(locked_damp_in))
      else $error("locked settings not used with fast acquire off");

   a_fast_acq_sel: assert property (
      $past(rst_n_in) && $past(fast_q) && !$past(phase_locked_in) |->
         loop_bw_out == $past(acq_bw_in) && loop_damp_out == $past(acq_damp_in))
      else $error("acquisition settings not used before lock");

   a_window_cmp: assert property (
      $past(rst_n_in) |-> in_window_out == ($past(phase_err_in) <= $past(win_q)))
      else $error("window decision wrong");

   a_avg_off: assert property (
      $past(rst_n_in) && !$past(havg_q) |-> avg_mode_out == DPFC_AVG_OFF)
      else $error("averaging active while disabled");

   a_avg_mid: assert property (
      $past(rst_n_in) && $past(havg_q) && $past(hold_mode_in) == DPFC_HM_MID
         |-> avg_mode_out == DPFC_AVG_MID)
      else $error("mid-supply mode not selected");

   a_fb_follow: assert property (
      reg_wr_in && reg_addr_in == DPFC_ADDR_FR0 |=>
         ##1 fb_value_out[7:0] == $past(reg_wdata_in, 2))
      else $error("fraction write not in feedback value");

   a_dsm_order: assert property (
      $past(rst_n_in) |-> dsm_order_out == $past(ord_q)
         && dsm_enable_out == ($past(ord_q) != DPFC_ORD_OFF))
      else $error("modulator enable and order disagree");

   a_gain_four: assert property (
      $past(rst_n_in) && $past(gain_q) == DPFC_GAIN_FOUR |->
         dco_err_out == ($past(dco_err_out) - $past(dco_err_out)
                         + ({{2{$past(freq_err_in[FE_W-1])}}, $past(freq_err_in)} <<< 2)))
      else $error("gain four scaling wrong");

   a_dither_max: assert property (
      $past(rst_n_in) && $past(dith_q) == 3'h7 |-> dither_amp_out == DPFC_DITH_MAX)
      else $error("top dither code not 64 LSBs");

   a_reset_dflt: assert property (
      !$past(rst_n_in) |-> win_q == DPFC_RST_WIN && int_q == DPFC_RST_INT
         && ord_q == DPFC_RST_ORD && gain_q == DPFC_RST_GAIN && fast_q == DPFC_RST_FAST
         && frac_q == DPFC_RST_FRAC && dith_q == DPFC_RST_DITH && havg_q == DPFC_RST_HAVG)
      else $error("defaults not loaded at reset");

   a_read_valid: assert property (
      reg_rd_in && reg_addr_in == DPFC_ADDR_ORD |=>
         reg_rvalid_out && reg_rdata_out[3] == 1'b0)
      else $error("read answer or reserved bit wrong");

   c_acq_to_lock: cover property (acquiring_out ##[1:20] !acquiring_out);
   c_dsm_off:     cover property (!dsm_enable_out);
   c_mid_supply:  cover property (avg_mode_out == DPFC_AVG_MID);
   c_win_outside: cover property (!in_window_out);

endmodule // dpfc_top

`default_nettype wire

//--- src/dpfc_pkg.sv
// Constants and types for the PLL feedback configuration block
package dpfc_pkg;
   // Byte addresses on the register port
   localparam logic [15:0] DPFC_ADDR_ENA  = 16'h0064;
   localparam logic [15:0] DPFC_ADDR_WIN  = 16'h0065;
   localparam logic [15:0] DPFC_ADDR_INTH = 16'h0066;
   localparam logic [15:0] DPFC_ADDR_INTL = 16'h0067;
   localparam logic [15:0] DPFC_ADDR_FR2  = 16'h0068;
   localparam logic [15:0] DPFC_ADDR_FR1  = 16'h0069;
   localparam logic [15:0] DPFC_ADDR_FR0  = 16'h006A;
   localparam logic [15:0] DPFC_ADDR_ORD  = 16'h006D;

   // Field positions
   localparam int DPFC_FAST_BIT = 0;
   localparam int DPFC_HAVG_BIT = 1;
   localparam int DPFC_ORD_HI   = 7;
   localparam int DPFC_ORD_LO   = 6;
   localparam int DPFC_GAIN_HI  = 5;
   localparam int DPFC_GAIN_LO  = 4;
   localparam int DPFC_DITH_HI  = 2;
   localparam int DPFC_INT_W    = 9;
   localparam int DPFC_FRAC_W   = 21;

   // Reset values
   localparam logic       DPFC_RST_FAST = 1'h0;
   localparam logic       DPFC_RST_HAVG = 1'h0;
   localparam logic [7:0] DPFC_RST_WIN  = 8'h3F;
   localparam logic [8:0] DPFC_RST_INT  = 9'h02D;
   localparam logic [20:0] DPFC_RST_FRAC = 21'h000000;
   localparam logic [1:0] DPFC_RST_ORD  = 2'h3;
   localparam logic [1:0] DPFC_RST_GAIN = 2'h1;
   localparam logic [2:0] DPFC_RST_DITH = 3'h0;

   // Field codes
   localparam logic [1:0] DPFC_ORD_OFF   = 2'h0;
   localparam logic [1:0] DPFC_GAIN_HALF = 2'h0;
   localparam logic [1:0] DPFC_GAIN_ONE  = 2'h1;
   localparam logic [1:0] DPFC_GAIN_TWO  = 2'h2;
   localparam logic [1:0] DPFC_GAIN_FOUR = 2'h3;
   localparam logic [2:0] DPFC_DITH_NONE = 3'h0;
   localparam logic [6:0] DPFC_DITH_LSB  = 7'h01;
   localparam logic [6:0] DPFC_DITH_MAX  = 7'h40;
   localparam logic [1:0] DPFC_HM_INST   = 2'h0;
   localparam logic [1:0] DPFC_HM_FAST   = 2'h1;
   localparam logic [1:0] DPFC_HM_MID    = 2'h3;

   // Timing: window step 2.5 ns, history look-back 100 ms
   localparam int DPFC_WIN_STEP_PS = 2500;
   localparam int DPFC_HIST_MS     = 100;
   localparam int DPFC_CLK_HZ      = 10_000_000;
   localparam int DPFC_HIST_CYC    = DPFC_HIST_MS * (DPFC_CLK_HZ / 1000);

   // Effective holdover averaging behaviour
   typedef enum logic [1:0] {
      DPFC_AVG_OFF,
      DPFC_AVG_INST,
      DPFC_AVG_FAST,
      DPFC_AVG_MID
   } dpfc_avg_t;
endpackage

//--- dv/testbench.sv
// Self-checking testbench for the PLL feedback configuration block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import dpfc_pkg::*;
   logic                sys_clk_in, rst_n_in, reg_wr_in, reg_rd_in, reg_rvalid_out;
   logic [15:0]         reg_addr_in;
   logic [7:0]          reg_wdata_in, reg_rdata_out, phase_err_in;
   logic                phase_locked_in, acquiring_out, in_window_out, hist_tick_out;
   logic [3:0]          locked_bw_in, acq_bw_in, loop_bw_out;
   logic [2:0]          locked_damp_in, acq_damp_in, loop_damp_out;
   logic [1:0]          hold_mode_in, dsm_order_out;
   logic                dsm_enable_out;
   dpfc_avg_t           avg_mode_out;
   logic [29:0]         fb_value_out;
   logic signed [15:0]  freq_err_in;
   logic signed [17:0]  dco_err_out, e18;
   logic [6:0]          dither_amp_out;
   int                  num_errors, total_checks;

   // Short history period keeps the tick scenario within a few cycles
   dpfc_top #(.FE_W(16), .HIST_CYCLES(16)) dut (
      .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
      .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
      .phase_locked_in(phase_locked_in), .locked_bw_in(locked_bw_in),
      .locked_damp_in(locked_damp_in), .acq_bw_in(acq_bw_in), .acq_damp_in(acq_damp_in),
      .loop_bw_out(loop_bw_out), .loop_damp_out(loop_damp_out),
      .acquiring_out(acquiring_out), .phase_err_in(phase_err_in),
      .in_window_out(in_window_out), .hold_mode_in(hold_mode_in),
      .avg_mode_out(avg_mode_out), .hist_tick_out(hist_tick_out),
      .fb_value_out(fb_value_out), .dsm_enable_out(dsm_enable_out),
      .dsm_order_out(dsm_order_out), .freq_err_in(freq_err_in),
      .dco_err_out(dco_err_out), .dither_amp_out(dither_amp_out));

   // Clock at 100 ns period
   initial begin
      sys_clk_in = 1'b0;
      forever #50 sys_clk_in = ~sys_clk_in;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      if (num_errors == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // One-cycle write strobe, launched just after an edge
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge sys_clk_in);
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      reg_wr_in    <= 1'b1;
      @(posedge sys_clk_in);
      reg_wr_in <= 1'b0;
   endtask

   // Read with a bounded wait for the valid pulse
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      int n;
      @(posedge sys_clk_in);
      reg_addr_in <= a;
      reg_rd_in   <= 1'b1;
      @(posedge sys_clk_in);
      reg_rd_in <= 1'b0;
      // The valid pulse stands only in the cycle after the taking edge
      #1;
      n = 0;
      while (reg_rvalid_out !== 1'b1 && n < 4) begin
         @(posedge sys_clk_in);
         #1;
         n++;
      end
      if (reg_rvalid_out !== 1'b1) begin
         num_errors++;
         conclude();
      end else begin
         chk(reg_rdata_out, exp);
      end
   endtask

   // Inputs land one edge later and outputs one more; settle past both
   task automatic settle();
      repeat (3) @(posedge sys_clk_in);
      #1;
   endtask

   task automatic t_reset();
      rd(DPFC_ADDR_ENA, 8'h00);
      rd(DPFC_ADDR_WIN, 8'h3F);
      rd(DPFC_ADDR_INTH, 8'h00);
      rd(DPFC_ADDR_INTL, 8'h2D);
      rd(DPFC_ADDR_FR0, 8'h00);
      rd(DPFC_ADDR_ORD, 8'hD0);
      rd(16'h006B, 8'h00); // Unmapped place reads zero
      chk(fb_value_out, {9'h02D, 21'h000000});
      chk({dsm_enable_out, dsm_order_out}, 3'h7);
      chk(dco_err_out, $signed(18'h3FFFD));
   endtask

   task automatic t_fast();
      chk({acquiring_out, loop_bw_out, loop_damp_out}, 8'h2D);
      wr(DPFC_ADDR_ENA, 8'h01);
      settle();
      chk({acquiring_out, loop_bw_out, loop_damp_out}, 8'h9A);
      @(posedge sys_clk_in);
      phase_locked_in <= 1'b1;
      settle();
      chk({acquiring_out, loop_bw_out, loop_damp_out}, 8'h2D);
      wr(DPFC_ADDR_ENA, 8'h00);
      phase_locked_in <= 1'b0;
      settle();
      chk({acquiring_out, loop_bw_out, loop_damp_out}, 8'h2D);
   endtask

   task automatic t_window();
      wr(DPFC_ADDR_WIN, 8'h10); // never zero
      phase_err_in <= 8'h10;
      settle();
      chk(in_window_out, 1'b1);
      @(posedge sys_clk_in);
      phase_err_in <= 8'h11;
      settle();
      chk(in_window_out, 1'b0);
      wr(DPFC_ADDR_WIN, 8'hFF); // never zero
      phase_err_in <= 8'hFF;
      settle();
      chk(in_window_out, 1'b1);
   endtask

   task automatic t_fb();
      wr(DPFC_ADDR_INTH, 8'h01);
      wr(DPFC_ADDR_INTL, 8'hA5);
      wr(DPFC_ADDR_FR2, 8'h1F);
      wr(DPFC_ADDR_FR1, 8'h3C);
      wr(DPFC_ADDR_FR0, 8'h55);
      settle();
      chk(fb_value_out, {9'h1A5, 21'h1F3C55});
      rd(DPFC_ADDR_FR2, 8'h1F);
   endtask

   task automatic t_order();
      for (int o = 0; o < 4; o++) begin
         wr(DPFC_ADDR_ORD, {o[1:0], 6'h10}); // reserved bit 3 left zero
         settle();
         chk({dsm_enable_out, dsm_order_out}, {o != 0, o[1:0]});
      end
   endtask

   task automatic t_gain();
      @(posedge sys_clk_in);
      freq_err_in <= -16'sd3;
      for (int g = 0; g < 4; g++) begin
         wr(DPFC_ADDR_ORD, {2'h3, g[1:0], 4'h0});
         settle();
         e18 = (g == 0) ? -18'sd2 : -18'sd3 <<< (g - 1);
         chk(dco_err_out, e18);
      end
   endtask

   task automatic t_dither();
      for (int d = 0; d < 8; d++) begin
         wr(DPFC_ADDR_ORD, {5'h1A, d[2:0]});
         settle();
         chk(dither_amp_out, (d == 0) ? 7'h00 : 7'h01 << (d - 1));
      end
   endtask

   task automatic t_hold();
      dpfc_avg_t exp_m [4] = '{DPFC_AVG_INST, DPFC_AVG_FAST, DPFC_AVG_OFF, DPFC_AVG_MID};
      int ticks;
      for (int en = 0; en < 2; en++) begin
         wr(DPFC_ADDR_ENA, {6'h00, en[0], 1'b0});
         for (int m = 0; m < 4; m++) begin
            @(posedge sys_clk_in);
            hold_mode_in <= m[1:0];
            settle();
            chk(avg_mode_out, (en == 0) ? DPFC_AVG_OFF : exp_m[m]);
         end
      end
      // History tick period shows as exactly three pulses in 48 cycles
      ticks = 0;
      repeat (48) begin
         @(posedge sys_clk_in);
         #1;
         ticks += int'(hist_tick_out === 1'b1);
      end
      chk(ticks, 3);
   endtask

   // Mid-run reset must bring back every default over earlier writes
   task automatic t_rerst();
      @(posedge sys_clk_in);
      rst_n_in <= 1'b0;
      repeat (2) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      settle();
      chk(fb_value_out, {9'h02D, 21'h000000});
      chk(dither_amp_out, 7'h00);
      rd(DPFC_ADDR_ENA, 8'h00);
      rd(DPFC_ADDR_WIN, 8'h3F);
      rd(DPFC_ADDR_INTL, 8'h2D);
      rd(DPFC_ADDR_FR2, 8'h00);
      rd(DPFC_ADDR_ORD, 8'hD0);
   endtask

   // Every input given a value at time zero; reset held 20 cycles
   initial begin
      num_errors = 0;
      total_checks = 0;
      rst_n_in = 1'b0;
      reg_addr_in = 16'h0000;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      reg_wdata_in = 8'h00;
      phase_locked_in = 1'b0;
      locked_bw_in = 4'h5;
      locked_damp_in = 3'h5;
      acq_bw_in = 4'h3;
      acq_damp_in = 3'h2;
      phase_err_in = 8'h00;
      hold_mode_in = 2'h0;
      freq_err_in = -16'sd3;
      repeat (20) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      settle();
      t_reset();
      t_fast();
      t_window();
      t_fb();
      t_order();
      t_gain();
      t_dither();
      t_hold();
      t_rerst();
      conclude();
   end
endmodule // testbench
`default_nettype wire
